// File: rtl/fwg_host.sv
`timescale 1ns/100ps
// Summary of operation
// - Host holds pins non-writing when idle.
// - Write needs chip-select, strobe low, OE high.
// - Protect: high level on address pin and OE.
// - Unprotect: high level, chip-select low, pulse strobe.
// - Protect all sectors before chip unprotect.
module fwg_host
  import fwg_pkg::*;
#(
  parameter int SECTORS = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire fwg_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_valid,
  output logic rsp_protected,
  output fwg_pins_t pins,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic lockout_active
);

  initial begin
    if (SECTORS != (1 << SECT_W)) begin
      $error("fwg_host sector count must match the sector field");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h2,
    ST_HOLD = 3'h3,
    ST_SAMPLE = 3'h4,
    ST_DONE = 3'h5
  } fwg_state_t;

  // ---------------------------------------------------------------------------
  // Synchronised pins
  // ---------------------------------------------------------------------------
  logic [DATA_W:0] sync_vec;

  fwg_pin_sync #(
    .WIDTH(DATA_W + 1)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in({lockout_active, dq_in}),
    .sync_out(sync_vec)
  );

  logic lockout_s;
  logic [DATA_W-1:0] dq_s;
  assign lockout_s = sync_vec[DATA_W];
  assign dq_s = sync_vec[DATA_W-1:0];

  // ---------------------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------------------
  fwg_state_t state_reg, state_next;
  fwg_req_t cur_reg, cur_next;
  fwg_pins_t pins_reg, pins_next;
  logic [DATA_W-1:0] dq_out_reg, dq_out_next;
  logic dq_oe_n_reg, dq_oe_n_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DATA_W-1:0] rsp_reg, rsp_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [SECTORS-1:0] prot_seen_reg, prot_seen_next;

  // Idle pin state: all strobes high and nothing at the high level.
  function automatic fwg_pins_t idle_pins(input logic [ADDR_W-1:0] a);
    fwg_pins_t p;
    p.ce_n = 1'b1;
    p.oe_n = 1'b1;
    p.we_n = 1'b1;
    p.oe_hv = 1'b0;
    p.addr_hv = 1'b0;
    p.addr = a;
    idle_pins = p;
  endfunction

  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    pins_next = pins_reg;
    dq_out_next = dq_out_reg;
    dq_oe_n_next = dq_oe_n_reg;
    cnt_next = cnt_reg;
    rsp_next = rsp_reg;
    rsp_valid_next = 1'b0;
    prot_seen_next = prot_seen_reg;
    unique case (state_reg)
      ST_IDLE: begin
        pins_next = idle_pins(pins_reg.addr);
        dq_oe_n_next = 1'b1;
        // A device below lockout would drop the cycle anyway, so wait.
        if (req_valid && !lockout_s) begin
          cur_next = req;
          pins_next.addr = req.addr;
          cnt_next = CNT_W'(SETUP_CYC);
          state_next = ST_SETUP;
          unique case (req.op)
            FWG_OP_READ, FWG_OP_SYS_CHECK: begin
              pins_next.addr[ID_SELECT_BIT] = (req.op == FWG_OP_SYS_CHECK) ? 1'b1
                                              : req.addr[ID_SELECT_BIT];
            end
            FWG_OP_WRITE: begin
              dq_out_next = req.data;
              dq_oe_n_next = 1'b0;
            end
            FWG_OP_PROTECT: begin
              pins_next.addr_hv = 1'b1;
              pins_next.oe_hv = 1'b1;
              prot_seen_next[req.addr[ADDR_W-1 -: SECT_W]] = 1'b1;
            end
            FWG_OP_VERIFY: begin
              pins_next.addr_hv = 1'b1;
              pins_next.addr[ID_SELECT_BIT] = 1'b1;
              pins_next.addr[LOW_ORDER_BIT] = 1'b0;
              pins_next.addr[PROTECT_MODE_BIT] = 1'b0;
            end
            FWG_OP_UNPROTECT: begin
              // Unprotect starts only from a chip whose every sector this host has
              // protected since reset or the last unprotect; otherwise it is answered without a strobe.
              if (&prot_seen_reg) begin
                pins_next.addr_hv = 1'b1;
                pins_next.oe_hv = 1'b1;
                pins_next.addr[PROTECT_MODE_BIT] = 1'b1;
                prot_seen_next = '0;
              end else begin
                rsp_next = UNPROTECTED_CODE;
                state_next = ST_DONE;
              end
            end
            default: begin
              rsp_next = UNPROTECTED_CODE;
              state_next = ST_DONE;
            end
          endcase
        end
      end
      ST_SETUP: begin
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == CNT_W'(1)) begin
          pins_next.ce_n = 1'b0;
          if (cur_reg.op == FWG_OP_WRITE) begin
            pins_next.oe_n = 1'b1;
            pins_next.we_n = 1'b0;
            cnt_next = CNT_W'(STROBE_CYC);
            state_next = ST_STROBE;
          end else if (cur_reg.op == FWG_OP_PROTECT || cur_reg.op == FWG_OP_UNPROTECT) begin
            pins_next.we_n = 1'b0;
            cnt_next = CNT_W'(STROBE_CYC);
            state_next = ST_STROBE;
          end else begin
            pins_next.oe_n = 1'b0;
            pins_next.we_n = 1'b1;
            cnt_next = CNT_W'(ACCESS_CYC);
            state_next = ST_SAMPLE;
          end
        end
      end
      ST_STROBE: begin
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == CNT_W'(1)) begin
          pins_next.we_n = 1'b1;
          cnt_next = CNT_W'(SETUP_CYC);
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == CNT_W'(1)) begin
          pins_next = idle_pins(pins_reg.addr);
          dq_oe_n_next = 1'b1;
          rsp_next = UNPROTECTED_CODE;
          state_next = ST_DONE;
        end
      end
      ST_SAMPLE: begin
        cnt_next = cnt_reg - CNT_W'(1);
        // Wait ACCESS_CYC cycles in all, synchroniser depth included, before taking the data.
        if (cnt_reg == CNT_W'(1)) begin
          rsp_next = dq_s;
          pins_next = idle_pins(pins_reg.addr);
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        rsp_valid_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cur_reg <= '0;
      pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, oe_hv: 1'b0, addr_hv: 1'b0,
                    addr: '0};
      dq_out_reg <= '0;
      dq_oe_n_reg <= 1'b1;
      cnt_reg <= '0;
      rsp_reg <= '0;
      rsp_valid_reg <= 1'b0;
      prot_seen_reg <= '0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      pins_reg <= pins_next;
      dq_out_reg <= dq_out_next;
      dq_oe_n_reg <= dq_oe_n_next;
      cnt_reg <= cnt_next;
      rsp_reg <= rsp_next;
      rsp_valid_reg <= rsp_valid_next;
      prot_seen_reg <= prot_seen_next;
    end
  end

  assign req_ready = (state_reg == ST_IDLE) && !lockout_s;
  assign pins = pins_reg;
  assign dq_out = dq_out_reg;
  assign dq_oe_n = dq_oe_n_reg;
  assign rsp_data = rsp_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_protected = rsp_reg[PROTECT_STATUS_BIT];

endmodule

// File: rtl/fwg_pin_sync.sv
`timescale 1ns/100ps
module fwg_pin_sync
  import fwg_pkg::*;
#(
  parameter int WIDTH = 9
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  initial begin
    if (WIDTH < 1) begin
      $error("fwg_pin_sync width must be positive");
    end
  end

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // ---------------------------------------------------------------------------
  // Two-stage synchroniser; the first stage feeds only the second.
  // ---------------------------------------------------------------------------
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// File: rtl/fwg_pkg.sv
package fwg_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // Strobe pulses are held well beyond the glitch filter width.
  localparam int GLITCH_NS = 5;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_NS = 90;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_EXTRA_NS = 30;
  localparam int SLEEP_CYC =
    (ACCESS_NS + SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_BUSY_US = 2;
  localparam int PROG_BUSY_CYC = PROG_BUSY_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_BUSY_US = 100;
  localparam int ERASE_BUSY_CYC = ERASE_BUSY_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ---------------------------------------------------------------------------
  // Address and data layout
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int SECT_W = 3;
  localparam int LOW_ORDER_BIT = 0;
  localparam int ID_SELECT_BIT = 1;
  localparam int PROTECT_MODE_BIT = 6;
  localparam int HV_ADDR_BIT = 9;
  localparam int PROTECT_STATUS_BIT = 0;
  localparam logic [DATA_W-1:0] UNPROTECTED_CODE = 8'h00;
  localparam logic [DATA_W-1:0] READ_ID_CMD = 8'h90;
  localparam logic [DATA_W-1:0] RESET_CMD = 8'hF0;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 19'h002AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'hAA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;

  typedef enum logic [2:0] {
    FWG_OP_READ = 3'h0,
    FWG_OP_WRITE = 3'h1,
    FWG_OP_PROTECT = 3'h2,
    FWG_OP_VERIFY = 3'h3,
    FWG_OP_UNPROTECT = 3'h4,
    FWG_OP_SYS_CHECK = 3'h5
  } fwg_op_t;

  typedef struct packed {
    fwg_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fwg_req_t;

  // Pin bundle toward the flash; hv flags ask the board to raise the high level.
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic oe_hv;
    logic addr_hv;
    logic [ADDR_W-1:0] addr;
  } fwg_pins_t;

  function automatic logic [ADDR_W-1:0] fwg_sect_addr(input logic [SECT_W-1:0] s,
                                                      input logic [ADDR_W-1:0] low);
    fwg_sect_addr = {s, low[ADDR_W-SECT_W-1:0]};
  endfunction

endpackage

// File: verif/fwg_flash_model.sv
`timescale 1ns/100ps
module fwg_flash_model
  import fwg_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value.
  parameter logic [7:0] PART_ID = 8'h3C // Arbitrary value.
) (
  input wire fwg_pins_t pins,
  input wire logic lockout_active,
  input wire logic [DATA_W-1:0] dq_w,
  output logic [DATA_W-1:0] dq
);
  logic [7:0] prot;
  logic id_mode;
  logic [7:0] val;
  int step;
  realtime t_fall;
  initial begin
    prot = 8'h00;
    id_mode = 1'b0;
    step = 0;
    val = 8'h00;
  end
  always @(negedge pins.we_n) t_fall = $realtime;
  always @(posedge lockout_active) begin
    id_mode = 1'b0;
    step = 0;
  end
  always @(posedge pins.we_n) begin
    if (!lockout_active && !pins.ce_n && $realtime - t_fall >= 5.0) begin
      if (pins.oe_hv && pins.addr_hv) begin
        if (pins.addr[PROTECT_MODE_BIT]) prot = 8'h00;
        else prot[pins.addr[18:16]] = 1'b1;
      end else if (pins.oe_n) begin
        if (dq_w == RESET_CMD) step = 9;
        else if (step == 0 && pins.addr == UNLOCK_ADDR1 && dq_w == UNLOCK_DATA1) step = 1;
        else if (step == 1 && pins.addr == UNLOCK_ADDR2 && dq_w == UNLOCK_DATA2) step = 2;
        else if (step == 2 && pins.addr == UNLOCK_ADDR1 && dq_w == READ_ID_CMD) step = 8;
        else step = 0;
        if (step >= 8) id_mode = (step == 8);
        if (step >= 8) step = 0;
      end
    end
  end
  // ----------------------------------------
  // A released bus shows the inverse of its last value, never a steady guess.
  // ----------------------------------------
  always @* begin
    if (!pins.ce_n && !pins.oe_n && pins.we_n) begin
      if (pins.addr_hv || id_mode) begin
        if (pins.addr[ID_SELECT_BIT]) val = {7'h00, prot[pins.addr[18:16]]};
        else val = pins.addr[0] ? PART_ID : MAKER_ID;
      end else val = pins.addr[7:0];
      dq = val;
    end else dq = ~val;
  end
endmodule

// File: verif/fwg_host_chk.sv
`timescale 1ns/100ps
module fwg_host_chk
  import fwg_pkg::*;
#(
  parameter int SECTORS = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire fwg_req_t req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_protected,
  input wire fwg_pins_t pins,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic lockout_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_lock_refuse: assert property (lockout_active [*3] |-> !req_ready)
    else $error("request accepted during supply lockout");
  a_write_inhibit: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n)
    else $error("strobe low without a write condition");
  a_idle_pins: assert property (req_ready |-> pins.ce_n && pins.we_n && pins.oe_n
    && !pins.oe_hv && !pins.addr_hv) else $error("pins not idle while ready");
  a_strobe_width: assert property ($fell(pins.we_n) |-> !pins.we_n [*8])
    else $error("strobe pulse too short");
  a_strobe_end: assert property ($fell(pins.we_n) |-> ##[8:12] $rose(pins.we_n))
    else $error("strobe did not end in time");
  a_protect_hv: assert property (pins.oe_hv |-> pins.addr_hv && pins.oe_n)
    else $error("high level on enable without address pin");
  a_verify_addr: assert property (pins.addr_hv && !pins.oe_n |-> pins.we_n
    && pins.addr[ID_SELECT_BIT] && !pins.addr[LOW_ORDER_BIT] && !pins.addr[PROTECT_MODE_BIT])
    else $error("bad verify address");
  a_answer_bound: assert property (req_valid && req_ready |-> ##[2:20] rsp_valid)
    else $error("no answer to request");
  a_status_bit: assert property ($changed(rsp_data) |=> rsp_valid)
    else $error("new answer data without a valid pulse");
  a_dq_contend: assert property (!dq_oe_n |-> pins.oe_n && !pins.oe_hv)
    else $error("host drives data while flash may drive");
endmodule
bind fwg_host fwg_host_chk #(.SECTORS(SECTORS)) u_chk (.ref_clk(ref_clk), .reset(reset),
  .req(req), .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data),
  .rsp_valid(rsp_valid), .rsp_protected(rsp_protected), .pins(pins), .dq_out(dq_out),
  .dq_oe_n(dq_oe_n), .dq_in(dq_in), .lockout_active(lockout_active));

// File: verif/tb.sv
`timescale 1ns/100ps
module tb;
  import fwg_pkg::*;
  typedef struct packed {fwg_op_t op; logic [18:0] a; logic [7:0] d; logic [7:0] e;} fwg_row_t;
  logic ref_clk, reset, req_valid, req_ready, rsp_valid, rsp_protected, dq_oe_n;
  logic lockout_active;
  fwg_req_t req;
  fwg_pins_t pins;
  logic [7:0] rsp_data, dq_out, flash_dq, bus, got;
  int n_mismatch, cmp_count;
  fwg_row_t rows[26] = '{
    '{FWG_OP_READ, 19'h00012, 8'h00, 8'h12}, '{FWG_OP_VERIFY, 19'h30000, 8'h00, 8'h00},
    '{FWG_OP_PROTECT, 19'h30000, 8'h00, 8'h00}, '{FWG_OP_VERIFY, 19'h30000, 8'h00, 8'h01},
    '{FWG_OP_VERIFY, 19'h20000, 8'h00, 8'h00}, '{FWG_OP_WRITE, 19'h00555, 8'hAA, 8'h00},
    '{FWG_OP_WRITE, 19'h002AA, 8'h55, 8'h00}, '{FWG_OP_WRITE, 19'h00555, 8'h90, 8'h00},
    '{FWG_OP_SYS_CHECK, 19'h30000, 8'h00, 8'h01}, '{FWG_OP_SYS_CHECK, 19'h50000, 8'h00, 8'h00},
    '{FWG_OP_READ, 19'h00000, 8'h00, 8'hA5}, '{FWG_OP_READ, 19'h00001, 8'h00, 8'h3C},
    '{FWG_OP_WRITE, 19'h00000, 8'hF0, 8'h00}, '{FWG_OP_WRITE, 19'h00555, 8'hAA, 8'h00},
    '{FWG_OP_WRITE, 19'h00555, 8'h90, 8'h00}, '{FWG_OP_READ, 19'h00034, 8'h00, 8'h34},
    '{FWG_OP_PROTECT, 19'h50000, 8'h00, 8'h00}, '{FWG_OP_PROTECT, 19'h00000, 8'h00, 8'h00},
    '{FWG_OP_PROTECT, 19'h10000, 8'h00, 8'h00}, '{FWG_OP_PROTECT, 19'h20000, 8'h00, 8'h00},
    '{FWG_OP_PROTECT, 19'h40000, 8'h00, 8'h00}, '{FWG_OP_PROTECT, 19'h60000, 8'h00, 8'h00},
    '{FWG_OP_PROTECT, 19'h70000, 8'h00, 8'h00}, '{FWG_OP_UNPROTECT, 19'h00000, 8'h00, 8'h00},
    '{FWG_OP_VERIFY, 19'h30000, 8'h00, 8'h00}, '{FWG_OP_VERIFY, 19'h50000, 8'h00, 8'h00}};
  assign bus = dq_oe_n ? flash_dq : dq_out;
  fwg_host dut (.ref_clk(ref_clk), .reset(reset), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .rsp_protected(rsp_protected), .pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dq_in(bus), .lockout_active(lockout_active));
  fwg_flash_model u_flash (.pins(pins), .lockout_active(lockout_active), .dq_w(bus),
    .dq(flash_dq));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_req(input fwg_op_t op, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (req_ready !== 1'b1 && n < 200);
    if (n >= 200) n_mismatch++;
    @(posedge ref_clk);
    req <= '{op: op, addr: a, data: d};
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    if (n >= 100) n_mismatch++;
    got = rsp_data;
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #50000;
    n_mismatch++;
    close_out();
  end
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    lockout_active = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      do_req(rows[i].op, rows[i].a, rows[i].d);
      check(got, rows[i].e);
      check({7'h00, rsp_protected}, {7'h00, rows[i].e[0]});
    end
    do_req(FWG_OP_PROTECT, 19'h30000, 8'h00);
    do_req(FWG_OP_UNPROTECT, 19'h00000, 8'h00);
    do_req(FWG_OP_VERIFY, 19'h30000, 8'h00);
    check(got, 8'h01);
    @(posedge ref_clk);
    lockout_active <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 check({7'h00, req_ready}, 8'h00);
    @(posedge ref_clk);
    lockout_active <= 1'b0;
    do_req(FWG_OP_READ, 19'h00056, 8'h00);
    check(got, 8'h56);
    @(posedge ref_clk);
    req <= '{op: FWG_OP_WRITE, addr: 19'h00555, data: 8'hAA};
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    #1 check({4'h0, pins.ce_n, pins.oe_n, pins.we_n, rsp_valid}, 8'h0E);
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    do_req(FWG_OP_READ, 19'h00012, 8'h00);
    check(got, 8'h12);
    close_out();
  end
endmodule
